//--- logic/ddc_decim_nco_select.sv
`include "ddc_map.svh"

module ddc_decim_nco_select #(
	parameter int SAMPLE_W = 14
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   regWrEn,
	input  wire logic                   regRdEn,
	input  wire logic [`DDC_ADDR_W-1:0] regAddr,
	input  wire logic [7:0]             regWrData,
	output logic      [7:0]             regRdData,
	input  wire logic [SAMPLE_W-1:0]    chanASample,
	input  wire logic [SAMPLE_W-1:0]    chanBSample,
	input  wire logic                   sampleValid,
	input  wire logic                   selectPinFirst,
	input  wire logic                   selectPinSecond,
	output logic      [SAMPLE_W-1:0]    iSample,
	output logic      [SAMPLE_W-1:0]    qSample,
	output logic                        sampleValidOut,
	output logic      [3:0]             activeChannel,
	output ddc_pkg::ddc_chain_type      chainCfg,
	output ddc_pkg::ddc_mix_type        mixCfg
);
	import ddc_pkg::*;

	logic [7:0]    ctrl_q;
	logic [7:0]    route_q;
	logic [7:0]    osc_q;
	logic [7:0]    rdMux;
	logic [2:0]    primarySel;
	logic [3:0]    extSel;
	logic          realSel;
	logic          routeI;
	logic          routeQ;
	ddc_chain_type chain_d;
	ddc_mix_type   mix_d;

	assign primarySel = ctrl_q[`DDC_CTRL_DEC_LSB +: 3];
	assign realSel    = ctrl_q[`DDC_CTRL_C2R_BIT];
	assign extSel     = route_q[`DDC_ROUTE_EXT_LSB +: 4];
	assign routeI     = route_q[`DDC_ROUTE_I_BIT];
	assign routeQ     = route_q[`DDC_ROUTE_Q_BIT];

	// control register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `DDC_CTRL_RST;
		end else if (regWrEn && regAddr == `DDC_CTRL_OFS) begin
			ctrl_q <= regWrData;
		end
	end

	// input route register; reserved bits 3 and 1 never store
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			route_q <= `DDC_ROUTE_RST;
		end else if (regWrEn && regAddr == `DDC_ROUTE_OFS) begin
			route_q <= regWrData & `DDC_ROUTE_MASK;
		end
	end

	// oscillator select register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			osc_q <= `DDC_OSC_RST;
		end else if (regWrEn && regAddr == `DDC_OSC_OFS) begin
			osc_q <= regWrData;
		end
	end

	always_comb begin
		case (regAddr)
			`DDC_CTRL_OFS:  rdMux = ctrl_q;
			`DDC_ROUTE_OFS: rdMux = route_q;
			`DDC_OSC_OFS:   rdMux = osc_q;
			default:        rdMux = 8'h00;
		endcase
	end

	// read data is held until the next read strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= rdMux;
		end
	end

	function automatic ddc_chain_type decodeChain(
		input logic [2:0] primary,
		input logic [3:0] ext,
		input logic       realOnly
	);
		ddc_chain_type c;
		c = '0;
		if (primary != `DDC_PRIMARY_EXT) begin
			c.stages.halfbandStageOne = 1'b1;
			case (primary)
				3'h0: begin
					c.stages.halfbandStageTwo = 1'b1;
					c.ratio = 6'h04;
				end
				3'h1: begin
					c.stages.halfbandStageTwo   = 1'b1;
					c.stages.halfbandStageThree = 1'b1;
					c.ratio = 6'h08;
				end
				3'h2: begin
					c.stages.halfbandStageTwo   = 1'b1;
					c.stages.halfbandStageThree = 1'b1;
					c.stages.halfbandStageFour  = 1'b1;
					c.ratio = 6'h10;
				end
				3'h3: begin
					c.ratio = 6'h02;
				end
				3'h4: begin
					c.stages.thirdbandStageTwo = 1'b1;
					c.ratio = 6'h06;
				end
				3'h5: begin
					c.stages.halfbandStageTwo  = 1'b1;
					c.stages.thirdbandStageTwo = 1'b1;
					c.ratio = 6'h0c;
				end
				default: begin
					c.stages.halfbandStageTwo   = 1'b1;
					c.stages.halfbandStageThree = 1'b1;
					c.stages.thirdbandStageTwo  = 1'b1;
					c.ratio = 6'h18;
				end
			endcase
		end else begin
			// upper nibble of the route register takes over
			case (ext)
				4'h0: begin
					c.stages.halfbandStageOne   = 1'b1;
					c.stages.halfbandStageTwo   = 1'b1;
					c.stages.halfbandStageThree = 1'b1;
					c.stages.halfbandStageFour  = 1'b1;
					c.stages.thirdbandStageTwo  = 1'b1;
					c.ratio = 6'h30;
				end
				4'h2: begin
					c.stages.halfbandStageOne = 1'b1;
					c.stages.fifthbandStage   = 1'b1;
					c.ratio = 6'h0a;
				end
				4'h3: begin
					c.stages.halfbandStageOne = 1'b1;
					c.stages.halfbandStageTwo = 1'b1;
					c.stages.fifthbandStage   = 1'b1;
					c.ratio = 6'h14;
				end
				4'h4: begin
					c.stages.halfbandStageOne   = 1'b1;
					c.stages.halfbandStageTwo   = 1'b1;
					c.stages.halfbandStageThree = 1'b1;
					c.stages.fifthbandStage     = 1'b1;
					c.ratio = 6'h28;
				end
				4'h7: begin
					c.stages.thirdbandStageOne = 1'b1;
					c.ratio = 6'h03;
				end
				4'h8: begin
					c.stages.fifthbandStage    = 1'b1;
					c.stages.thirdbandStageOne = 1'b1;
					c.ratio = 6'h0f;
				end
				4'h9: begin
					c.stages.halfbandStageTwo  = 1'b1;
					c.stages.fifthbandStage    = 1'b1;
					c.stages.thirdbandStageOne = 1'b1;
					c.ratio = 6'h1e;
				end
				default: begin
					c.unsupported = 1'b1;
				end
			endcase
		end
		if (realOnly) begin
			// third-band one chains have no half-rate real form
			if (c.stages.thirdbandStageOne) begin
				c.unsupported = 1'b1;
			end else begin
				c.ratio = {1'b0, c.ratio[5:1]};
			end
		end
		return c;
	endfunction : decodeChain

	always_comb begin
		chain_d = decodeChain(primarySel, extSel, realSel);
		mix_d.mixerComplex = ctrl_q[`DDC_CTRL_MIX_BIT];
		mix_d.gainDouble   = ctrl_q[`DDC_CTRL_GAIN_BIT];
		mix_d.ifMode       = ctrl_q[`DDC_CTRL_IF_LSB +: 2];
		mix_d.realOnly     = realSel;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chainCfg <= '0;
			mixCfg   <= '0;
		end else begin
			chainCfg <= chain_d;
			mixCfg   <= mix_d;
		end
	end

	// channel routing toward the mixer inputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iSample        <= '0;
			qSample        <= '0;
			sampleValidOut <= 1'b0;
		end else begin
			sampleValidOut <= sampleValid;
			if (sampleValid) begin
				iSample <= routeI ? chanBSample : chanASample;
				qSample <= routeQ ? chanBSample : chanASample;
			end
		end
	end

	ddc_osc_channel_select uOscSel (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.oscMode         (osc_q[`DDC_OSC_MODE_LSB +: 4]),
		.regChannel      (osc_q[`DDC_OSC_CHAN_LSB +: 4]),
		.selectPinFirst  (selectPinFirst),
		.selectPinSecond (selectPinSecond),
		.activeChannel   (activeChannel)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	route_i_path_a: assert property (
		sampleValid && !routeI |=> iSample == $past(chanASample))
		else $error("I input not taken from channel A");

	route_q_path_a: assert property (
		sampleValid && routeQ |=> qSample == $past(chanBSample))
		else $error("Q input not taken from channel B");

	ext_field_gate_a: assert property (
		primarySel == 3'h0 && !realSel ##1 primarySel == 3'h0 && !realSel
		|-> chainCfg.ratio == 6'h04 && !chainCfg.stages.fifthbandStage)
		else $error("extended field leaked into the primary decimation");

	ext_zero_chain_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h0 && realSel
		|=> chainCfg.ratio == 6'h18 && chainCfg.stages.thirdbandStageTwo)
		else $error("extended code zero real ratio is not 24");

	fifth_band_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h4 && !realSel
		|=> chainCfg.ratio == 6'h28 && chainCfg.stages.fifthbandStage)
		else $error("fifth-band chain ratio is not 40");

	third_real_bad_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h8 && realSel
		|=> chainCfg.unsupported && chainCfg.ratio == 6'h0f)
		else $error("real output accepted on a third-band one chain");

	route_reserved_a: assert property (
		regRdEn && regAddr == `DDC_ROUTE_OFS
		|=> regRdData[3] == 1'b0 && regRdData[1] == 1'b0)
		else $error("reserved route bits read as one");

	regmap_channel_a: assert property (
		osc_q[`DDC_OSC_MODE_LSB +: 4] == 4'h0 [*2]
		|-> activeChannel == $past(osc_q[`DDC_OSC_CHAN_LSB +: 4]))
		else $error("register channel not applied in register mode");

	channel_on_edge_a: assert property (
		$changed(activeChannel) |-> $past(osc_q[`DDC_OSC_MODE_LSB +: 4]) inside
		{4'h0, 4'h1, 4'h8, 4'ha})
		else $error("active channel changed under an unlisted mode");

	ext_ignored_a: assert property (
		primarySel != `DDC_PRIMARY_EXT && extSel != 4'h0
		|=> !chainCfg.stages.fifthbandStage && !chainCfg.stages.thirdbandStageOne)
		else $error("extended field acted without the primary code");

	ext_zero_complex_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h0 && !realSel
		|=> chainCfg.ratio == 6'h30 && chainCfg.stages.halfbandStageFour)
		else $error("extended code zero complex ratio is not 48");

	fifth_band_short_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h2 && realSel
		|=> chainCfg.ratio == 6'h05 && !chainCfg.stages.halfbandStageTwo)
		else $error("fifth-band real ratio is not 5");

	third_band_only_a: assert property (
		primarySel == `DDC_PRIMARY_EXT && extSel == 4'h7 && !realSel
		|=> chainCfg.ratio == 6'h03 && chainCfg.stages == 7'h04)
		else $error("third-band one chain is not used alone");

	real_half_rate_a: assert property (
		primarySel == 3'h0 && realSel
		|=> chainCfg.ratio == 6'h02 && mixCfg.realOnly)
		else $error("real output did not halve the primary ratio");

endmodule : ddc_decim_nco_select

//--- logic/ddc_map.svh
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

`define DDC_ADDR_W        15
`define DDC_CTRL_OFS      15'h0330
`define DDC_ROUTE_OFS     15'h0331
`define DDC_OSC_OFS       15'h0334

`define DDC_CTRL_RST      8'h00
`define DDC_ROUTE_RST     8'h05
`define DDC_OSC_RST       8'h00
`define DDC_ROUTE_MASK    8'hf5

`define DDC_CTRL_MIX_BIT  7
`define DDC_CTRL_GAIN_BIT 6
`define DDC_CTRL_IF_LSB   4
`define DDC_CTRL_C2R_BIT  3
`define DDC_CTRL_DEC_LSB  0
`define DDC_ROUTE_EXT_LSB 4
`define DDC_ROUTE_Q_BIT   2
`define DDC_ROUTE_I_BIT   0
`define DDC_OSC_MODE_LSB  4
`define DDC_OSC_CHAN_LSB  0

`define DDC_PRIMARY_EXT   3'h7

`endif

//--- logic/ddc_osc_channel_select.sv
`include "ddc_map.svh"

module ddc_osc_channel_select (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [3:0]  oscMode,
	input  wire logic [3:0]  regChannel,
	input  wire logic        selectPinFirst,
	input  wire logic        selectPinSecond,
	output logic      [3:0]  activeChannel
);
	import ddc_pkg::*;

	logic [1:0] pinMeta_q;
	logic [1:0] pinSync_q;
	logic [1:0] pinPrev_q;
	logic [1:0] pinRise;
	logic [3:0] counter_q;
	logic [3:0] counter_d;
	logic       edgeMode;
	logic       stepNow;
	logic [3:0] activeChannel_d;

	// two flops per pin before any logic looks at it
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSync
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pinMeta_q[g] <= 1'b0;
					pinSync_q[g] <= 1'b0;
					pinPrev_q[g] <= 1'b0;
				end else begin
					pinMeta_q[g] <= g == 0 ? selectPinFirst : selectPinSecond;
					pinSync_q[g] <= pinMeta_q[g];
					pinPrev_q[g] <= pinSync_q[g];
				end
			end
			assign pinRise[g] = pinSync_q[g] & ~pinPrev_q[g];
		end
	endgenerate

	always_comb begin
		edgeMode = 1'b0;
		stepNow  = 1'b0;
		case (oscMode)
			DDC_MODE_EDGE_A: begin
				edgeMode = 1'b1;
				stepNow  = pinRise[0];
			end
			DDC_MODE_EDGE_B: begin
				edgeMode = 1'b1;
				stepNow  = pinRise[1];
			end
			default: begin
				edgeMode = 1'b0;
				stepNow  = 1'b0;
			end
		endcase
	end

	always_comb begin
		counter_d = counter_q;
		if (!edgeMode) begin
			counter_d = 4'h0;
		end else if (stepNow) begin
			if (counter_q >= regChannel) begin
				counter_d = 4'h0;
			end else begin
				counter_d = counter_q + 4'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			counter_q <= 4'h0;
		end else begin
			counter_q <= counter_d;
		end
	end

	always_comb begin
		case (oscMode)
			DDC_MODE_REGMAP: activeChannel_d = regChannel;
			DDC_MODE_PINS:   activeChannel_d = {2'h0, pinSync_q[1], pinSync_q[0]};
			DDC_MODE_EDGE_A,
			DDC_MODE_EDGE_B: activeChannel_d = counter_q;
			default:         activeChannel_d = activeChannel;
		endcase
	end

	// mixer sees a new channel only on a clock edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			activeChannel <= 4'h0;
		end else begin
			activeChannel <= activeChannel_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	pin_mode_follow_a: assert property (
		oscMode == DDC_MODE_PINS |=> activeChannel == $past({2'h0, pinSync_q}))
		else $error("pin mode channel does not follow the select pins");

	counter_wrap_a: assert property (
		edgeMode && stepNow && counter_q >= regChannel |=> counter_q == 4'h0)
		else $error("edge counter did not wrap at the programmed limit");

	counter_step_a: assert property (
		edgeMode && stepNow && counter_q < regChannel
		|=> counter_q == $past(counter_q) + 4'h1)
		else $error("edge counter did not advance on a pin edge");

endmodule : ddc_osc_channel_select

//--- logic/ddc_pkg.sv
package ddc_pkg;

	typedef enum logic [3:0] {
		DDC_MODE_REGMAP = 4'h0,
		DDC_MODE_PINS   = 4'h1,
		DDC_MODE_EDGE_A = 4'h8,
		DDC_MODE_EDGE_B = 4'ha
	} ddc_osc_mode_type;

	typedef struct packed {
		logic halfbandStageOne;
		logic halfbandStageTwo;
		logic halfbandStageThree;
		logic halfbandStageFour;
		logic thirdbandStageOne;
		logic thirdbandStageTwo;
		logic fifthbandStage;
	} ddc_stage_type;

	typedef struct packed {
		ddc_stage_type stages;
		logic [5:0]    ratio;
		logic          unsupported;
	} ddc_chain_type;

	typedef struct packed {
		logic       mixerComplex;
		logic       gainDouble;
		logic [1:0] ifMode;
		logic       realOnly;
	} ddc_mix_type;

endpackage : ddc_pkg

//--- tb/ddc_decim_nco_select_test.sv
`include "ddc_map.svh"

module ddc_decim_nco_select_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ddc_pkg::*;

	logic                   ref_clk;
	logic                   rst;
	logic                   regWrEn;
	logic                   regRdEn;
	logic [`DDC_ADDR_W-1:0] regAddr;
	logic [7:0]             regWrData;
	logic [7:0]             regRdData;
	logic [13:0]            chanASample;
	logic [13:0]            chanBSample;
	logic                   sampleValid;
	logic                   selectPinFirst;
	logic                   selectPinSecond;
	logic [13:0]            iSample;
	logic [13:0]            qSample;
	logic                   sampleValidOut;
	logic [3:0]             activeChannel;
	ddc_chain_type          chainCfg;
	ddc_mix_type            mixCfg;
	int                     errTotal;
	int                     checksDone;
	int                     routeM;
	bit                     chkOn;
	bit                     armed;
	bit                     pend;
	logic [13:0]            expI;
	logic [13:0]            expQ;

	ddc_decim_nco_select #(.SAMPLE_W(14)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.chanASample(chanASample), .chanBSample(chanBSample),
		.sampleValid(sampleValid), .selectPinFirst(selectPinFirst),
		.selectPinSecond(selectPinSecond), .iSample(iSample),
		.qSample(qSample), .sampleValidOut(sampleValidOut),
		.activeChannel(activeChannel), .chainCfg(chainCfg), .mixCfg(mixCfg)
	);

	ddc_sample_source #(.SAMPLE_W(14)) i_src (
		.ref_clk(ref_clk), .rst(rst), .chanASample(chanASample),
		.chanBSample(chanBSample), .sampleValid(sampleValid)
	);

	always #12.5 ref_clk = ~ref_clk;

	task automatic stop_test;
		if (errTotal == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		checksDone++;
		if (e !== g) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		tick(1);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick(1);
		regWrEn = 1'b0;
	endtask : wr

	task automatic rd(input logic [14:0] a, input logic [7:0] e, input string nm);
		tick(1);
		regAddr = a;
		regRdEn = 1'b1;
		tick(1);
		regRdEn = 1'b0;
		check(nm, e, regRdData);
	endtask : rd

	task automatic pulse(input int pin);
		if (pin == 1) selectPinSecond = 1'b1;
		else selectPinFirst = 1'b1;
		tick(3);
		selectPinFirst = 1'b0;
		selectPinSecond = 1'b0;
		tick(3);
	endtask : pulse

	// chain model: seven stage flags msb first, then ratio, then unsupported
	function automatic logic [13:0] expChain(input int ext, input int re);
		int   st;
		int   ra;
		logic un;
		un = 1'b0;
		case (ext)
			0: begin st = 'h7a; ra = 48; end
			2: begin st = 'h41; ra = 10; end
			3: begin st = 'h61; ra = 20; end
			4: begin st = 'h71; ra = 40; end
			7: begin st = 'h04; ra = 3; end
			8: begin st = 'h05; ra = 15; end
			9: begin st = 'h25; ra = 30; end
			default: begin st = 0; ra = 0; un = 1'b1; end
		endcase
		if (re != 0 && ext >= 7 && ext <= 9) un = 1'b1;
		else if (re != 0) ra = ra / 2;
		return {st[6:0], ra[5:0], un};
	endfunction : expChain

	// sample path model, one cycle behind the inputs
	always @(negedge ref_clk) begin
		if (armed) begin
			check("sampleValidOut", pend, sampleValidOut);
			if (pend) begin
				check("iSample", expI, iSample);
				check("qSample", expQ, qSample);
			end
		end
		armed = chkOn;
		pend = sampleValid;
		expI = routeM[0] ? chanBSample : chanASample;
		expQ = routeM[2] ? chanBSample : chanASample;
	end

	initial begin
		#(25 * 20000);
		errTotal++;
		stop_test();
	end

	initial begin
		static int codes[8] = '{0, 2, 3, 4, 7, 8, 9, 5};
		int lim;
		int cnt;
		logic [7:0] d;
		ref_clk = 1'b0;
		rst = 1'b1;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = '0;
		regWrData = 8'h00;
		selectPinFirst = 1'b0;
		selectPinSecond = 1'b0;
		routeM = 5;
		void'($urandom(32'h906df1e0));
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		chkOn = 1'b1;
		rd(`DDC_CTRL_OFS, 8'h00, "ctrl reset");
		rd(`DDC_ROUTE_OFS, 8'h05, "route reset");
		rd(`DDC_OSC_OFS, 8'h00, "osc reset");
		rd(15'h0332, 8'h00, "unmapped read");
		wr(15'h0332, 8'hff);
		rd(15'h0332, 8'h00, "unmapped after write");
		for (int r = 0; r < 4; r++) begin
			d = {5'h00, r[1], 1'b0, r[0]};
			chkOn = 1'b0;
			wr(`DDC_ROUTE_OFS, d);
			routeM = d;
			tick(3);
			chkOn = 1'b1;
			tick(20);
			rd(`DDC_ROUTE_OFS, d, "route readback");
		end
		wr(`DDC_ROUTE_OFS, 8'hff);
		rd(`DDC_ROUTE_OFS, 8'hf5, "route reserved");
		for (int re = 0; re < 2; re++) begin
			foreach (codes[k]) begin
				d = ($urandom & 8'hf0) | (re << 3) | 8'h07;
				wr(`DDC_CTRL_OFS, d);
				wr(`DDC_ROUTE_OFS, {codes[k][3:0], 4'h5});
				tick(2);
				check("chainCfg", expChain(codes[k], re), chainCfg);
				check("mixCfg", {d[7:3]}, mixCfg);
			end
		end
		wr(`DDC_CTRL_OFS, 8'h08);
		wr(`DDC_ROUTE_OFS, 8'h45);
		tick(2);
		check("chainCfg primary", {7'h60, 6'd2, 1'b0}, chainCfg);
		selectPinFirst = 1'b1;
		for (int n = 0; n < 16; n++) begin
			wr(`DDC_OSC_OFS, n[7:0]);
			tick(3);
			check("activeChannel reg", n[3:0], activeChannel);
			rd(`DDC_OSC_OFS, n[7:0], "osc readback");
		end
		wr(`DDC_OSC_OFS, 8'h10);
		for (int p = 0; p < 4; p++) begin
			selectPinFirst = p[0];
			selectPinSecond = p[1];
			tick(4);
			check("activeChannel pins", {2'b00, p[1:0]}, activeChannel);
		end
		selectPinFirst = 1'b0;
		selectPinSecond = 1'b0;
		tick(3);
		for (int m = 0; m < 2; m++) begin
			// a non-edge mode in between clears the counter
			wr(`DDC_OSC_OFS, 8'h00);
			lim = $urandom % 16;
			wr(`DDC_OSC_OFS, {(m == 1) ? 4'ha : 4'h8, lim[3:0]});
			cnt = 0;
			// the other pin must not step the counter
			pulse(1 - m);
			check("activeChannel idle pin", 4'h0, activeChannel);
			for (int k = 0; k < lim + 2; k++) begin
				pulse(m);
				cnt = (cnt >= lim) ? 0 : cnt + 1;
				check("activeChannel edge", cnt[3:0], activeChannel);
			end
		end
		// reset in mid-run: outputs and registers return to defaults
		chkOn = 1'b0;
		tick(2);
		rst = 1'b1;
		tick(2);
		check("regRdData reset", 8'h00, regRdData);
		check("activeChannel reset", 4'h0, activeChannel);
		check("chainCfg reset", 14'h0000, chainCfg);
		check("sampleValidOut reset", 1'b0, sampleValidOut);
		rst = 1'b0;
		routeM = 5;
		chkOn = 1'b1;
		rd(`DDC_ROUTE_OFS, 8'h05, "route after reset");
		rd(`DDC_OSC_OFS, 8'h00, "osc after reset");
		check("chainCfg after reset", {7'h60, 6'd4, 1'b0}, chainCfg);
		tick(4);
		stop_test();
	end
endmodule : ddc_decim_nco_select_test

//--- tb/ddc_sample_source.sv
module ddc_sample_source #(
	parameter int SAMPLE_W = 14
) (
	input  wire logic                ref_clk,
	input  wire logic                rst,
	output logic      [SAMPLE_W-1:0] chanASample,
	output logic      [SAMPLE_W-1:0] chanBSample,
	output logic                     sampleValid
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		chanASample = '0;
		chanBSample = '0;
		sampleValid = 1'b0;
	end

	// fresh samples every cycle, with gaps in the qualifier
	always @(posedge ref_clk) begin
		#1;
		chanASample = rst ? '0 : SAMPLE_W'($urandom);
		chanBSample = rst ? '0 : SAMPLE_W'($urandom);
		sampleValid = !rst && ($urandom % 4 != 0);
	end
endmodule : ddc_sample_source
